// ===== src/flash_self_program_pkg.sv
// constants for the flash self-programming controller
// assumes an apb slave on one 40 mhz clock and a self-timed flash macro beside it
//
// Overview of operation
// RL1 - address is page register above effective address
// RL2 - low table access covers word bits 15..0
// RL3 - high table access covers word bits 23..16
// RL4 - rows hold 64 instructions, 192 bytes
// RL5 - page erase clears 512 aligned instructions
// RL6 - processor stalls while erase or program runs
// RL7 - start bit settable only, hardware clears it
// RL8 - program writes one 24-bit word
// RL9 - key 0x55 then 0xaa unlocks one start
// RL10 - software puts two nops after start
// RL11 - software erases page before reprogramming word
// RL12 - enable bit permits or inhibits operations
// RL13 - error flag set on improper start attempt
// RL14 - erase select picks erase or program variant
// RL15 - erase codes 1101 general, 0010 page
// RL16 - program code 0011 writes one word
// RL17 - control bits cleared only by power-on
// RL18 - last page erase clears configuration words
// RL19 - bits 12..7 and 5..4 read zero
// RL20 - key register write-only, low byte only
// RL21 - bad start sets error, starts nothing
package flash_self_program_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFF_TABLE_PAGE = 12'h000;
  localparam logic [11:0] OFF_EFF_ADDR   = 12'h004;
  localparam logic [11:0] OFF_TABLE_LOW  = 12'h008;
  localparam logic [11:0] OFF_TABLE_HIGH = 12'h00C;
  localparam logic [11:0] OFF_OP_CONTROL = 12'h010;
  localparam logic [11:0] OFF_UNLOCK_KEY = 12'h014;

  // ==========================================================
  // control register fields
  localparam int START_BIT     = 15;
  localparam int ENABLE_BIT    = 14;
  localparam int ERROR_BIT     = 13;
  localparam int ERASE_SEL_BIT = 6;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  // operation codes
  localparam logic [3:0] OP_ERASE_GENERAL = 4'b1101;
  localparam logic [3:0] OP_ERASE_PAGE    = 4'b0010;
  localparam logic [3:0] OP_PROGRAM_WORD  = 4'b0011;

  // unlock key bytes
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // ==========================================================
  // array geometry; two address units per instruction
  localparam int ROW_INSTRUCTIONS  = 64;
  localparam int ROW_BYTES         = 192;
  localparam int PAGE_ROWS         = 8;
  localparam int PAGE_INSTRUCTIONS = PAGE_ROWS * ROW_INSTRUCTIONS;
  localparam int PAGE_BYTES        = PAGE_ROWS * ROW_BYTES;
  localparam logic [23:0] PAGE_ADDR_MASK = 24'hFF_FC00;

  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } op_state_type;

  typedef enum logic [2:0] {
    KEY_LOCKED = 3'b001,
    KEY_HALF   = 3'b010,
    KEY_OPEN   = 3'b100
  } key_state_type;

  typedef enum logic [1:0] {
    CMD_NONE          = 2'd0,
    CMD_PROGRAM       = 2'd1,
    CMD_ERASE_PAGE    = 2'd2,
    CMD_ERASE_GENERAL = 2'd3
  } cmd_type;

endpackage

// ===== src/flash_self_program_control.sv
// flash self-programming controller: table access, unlock, self-timed sequencing
// assumes an apb master on pclk and a flash macro answering on the same clock
`timescale 1ns/10ps
`default_nettype none

module flash_self_program_control
  import flash_self_program_pkg::*;
#(
  parameter logic [23:0] LAST_PAGE_BASE = 24'h00_3C00
) (
  // clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        warm_reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash macro
  output logic      [23:0] flash_addr,
  output logic      [23:0] flash_wdata,
  output logic             flash_read,
  input  wire logic [23:0] flash_rdata,
  output logic             flash_program,
  output logic             flash_erase_page,
  output logic             flash_erase_general,
  input  wire logic        flash_done,
  output logic             config_words_cleared,
  // processor core
  output logic             cpu_stall
);

  // ==========================================================
  // helpers
  // byte-lane merge of a 16-bit field
  // a lane left unstrobed keeps its old byte
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  lanes);
    merge16 = {lanes[1] ? new_v[15:8] : old_v[15:8],
               lanes[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // operation decode from erase select and code
  function automatic cmd_type decode_cmd(input logic erase_v, input logic [3:0] op_v);
    decode_cmd = CMD_NONE;
    if (erase_v) begin
      if (op_v == OP_ERASE_GENERAL) decode_cmd = CMD_ERASE_GENERAL; // RL15
      else if (op_v == OP_ERASE_PAGE) decode_cmd = CMD_ERASE_PAGE; // RL15
    end else if (op_v == OP_PROGRAM_WORD) begin
      decode_cmd = CMD_PROGRAM; // RL16
    end
  endfunction

  // ==========================================================
  // state
  logic [7:0]    table_page;   // page register
  logic [15:0]   eff_addr;     // effective address
  logic [23:0]   word_latch;   // word being written
  logic          wr;           // start bit
  logic          program_enable; // enable bit
  logic          err;          // sequence error flag
  logic          erase_sel;    // erase select
  logic [3:0]    op_sel;       // operation code
  op_state_type  state;        // sequencer
  key_state_type key_state;    // unlock tracking
  cmd_type       cmd;          // command in flight
  logic [1:0]    rd_step;      // table read wait steps

  // ==========================================================
  // decode
  wire        access    = psel & penable;
  wire        setup     = psel & ~penable;
  wire        hit_page  = (paddr == OFF_TABLE_PAGE);
  wire        hit_eff   = (paddr == OFF_EFF_ADDR);
  wire        hit_low   = (paddr == OFF_TABLE_LOW);
  wire        hit_high  = (paddr == OFF_TABLE_HIGH);
  wire        hit_ctrl  = (paddr == OFF_OP_CONTROL);
  wire        hit_key   = (paddr == OFF_UNLOCK_KEY);
  wire        hit_tbl   = hit_low | hit_high;
  wire        hit_any   = hit_page | hit_eff | hit_tbl | hit_ctrl | hit_key;
  wire        tbl_read  = access & ~pwrite & hit_tbl;
  wire        wr_xfer   = access & pwrite & pready;
  wire [23:0] table_addr = {table_page, eff_addr}; // RL1
  wire        key_open  = (key_state == KEY_OPEN);

  // next control values as this write would leave them
  // the start write is judged on enable as this same write leaves it
  wire        start_try  = wr_xfer & hit_ctrl & pstrb[1] & pwdata[START_BIT];
  wire        next_program_enable = (wr_xfer & hit_ctrl & pstrb[1]) ? pwdata[ENABLE_BIT] :
                                    program_enable;
  wire        next_erase = (wr_xfer & hit_ctrl & pstrb[0]) ? pwdata[ERASE_SEL_BIT] : erase_sel;
  wire [3:0]  next_op    = (wr_xfer & hit_ctrl & pstrb[0]) ? pwdata[3:0] : op_sel;
  wire        launch     = start_try & key_open & next_program_enable; // RL9 RL12
  wire        bad_start  = start_try & ~launch; // RL13 RL21
  wire        done_err   = (state == ST_DONE);
  wire        next_err   = bad_start ? 1'b1 :
                           (wr_xfer & hit_ctrl & pstrb[1]) ? pwdata[ERROR_BIT] :
                           done_err ? 1'b0 : err;
  wire cmd_type launch_cmd = decode_cmd(next_erase, next_op); // RL14
  // a page spans eight rows of instructions, two address units each
  localparam logic [23:0] PAGE_SPAN_MASK = 24'(2 * PAGE_INSTRUCTIONS - 1); // RL4 RL5
  wire [23:0] page_base  = table_addr & ~PAGE_SPAN_MASK; // RL5

  // read view of control; unimplemented bits zero
  // only implemented bits carry state; the rest are tied off
  wire [15:0] ctrl_view = {wr, program_enable, err, 6'b00_0000,
                           erase_sel, 2'b00, op_sel}; // RL19

  // read data selection; key never reads back
  wire [31:0] read_mux =
    hit_page ? {24'h00_0000, table_page} :
    hit_eff  ? {16'h0000, eff_addr} :
    hit_low  ? {16'h0000, flash_rdata[15:0]} : // RL2
    hit_high ? {24'h00_0000, flash_rdata[23:16]} : // RL3
    hit_ctrl ? {16'h0000, ctrl_view} :
    32'h0000_0000; // RL20

  // ==========================================================
  // bus handshake; every access waits while an operation runs
  // hazard: a table read while busy would see a half-written word
  assign pready     = access & ~wr & (~tbl_read | (rd_step == 2'd2)); // RL6
  assign pslverr    = pready & ~hit_any;
  assign flash_read = tbl_read & ~wr & (rd_step == 2'd0);
  assign cpu_stall  = wr; // RL6

  // table read pacing: issue, capture, answer
  // two waits let the macro answer and the capture settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_step <= 2'd0;
    end else if (!warm_reset_n || pready) begin
      rd_step <= 2'd0;
    end else if (tbl_read && !wr && rd_step != 2'd2) begin
      rd_step <= rd_step + 2'd1;
    end
  end

  // read data register, loaded in setup or on flash capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup || rd_step == 2'd1) begin
      prdata <= read_mux;
    end
  end

  // ==========================================================
  // table page, address and write latch
  // the latch only feeds the macro data; nothing reads it back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_page <= 8'h00;
      eff_addr   <= 16'h0000;
      word_latch <= 24'h00_0000;
    end else if (wr_xfer) begin
      if (hit_page && pstrb[0]) table_page <= pwdata[7:0];
      if (hit_eff) eff_addr <= merge16(eff_addr, pwdata[15:0], pstrb[1:0]);
      if (hit_low) word_latch[15:0] <= merge16(word_latch[15:0], pwdata[15:0], pstrb[1:0]); // RL2
      if (hit_high && pstrb[0]) word_latch[23:16] <= pwdata[7:0]; // RL3
    end
  end
  assign flash_wdata = word_latch; // RL8

  // ==========================================================
  // unlock key: any write other than the key pair relocks
  // reads never relock, so software may poll status between key bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_state <= KEY_LOCKED;
    end else if (!warm_reset_n) begin
      key_state <= KEY_LOCKED;
    end else if (wr_xfer) begin
      if (hit_key && pstrb[0] && pwdata[7:0] == KEY_FIRST) key_state <= KEY_HALF; // RL9
      else if (hit_key && pstrb[0] && pwdata[7:0] == KEY_SECOND && key_state == KEY_HALF)
        key_state <= KEY_OPEN; // RL9
      else key_state <= KEY_LOCKED; // RL20
    end
  end

  // ==========================================================
  // control register; only presetn clears it, warm reset spares it
  // warm reset does not reach this process on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_enable <= CONTROL_RESET[ENABLE_BIT]; // RL17
      err       <= CONTROL_RESET[ERROR_BIT];
      erase_sel <= CONTROL_RESET[ERASE_SEL_BIT];
      op_sel    <= CONTROL_RESET[3:0];
    end else begin
      program_enable <= next_program_enable; // RL12
      err       <= next_err; // RL13
      erase_sel <= next_erase;
      op_sel    <= next_op;
    end
  end

  // ==========================================================
  // sequencer; a no-op code still passes through run and done
  // trade-off: no-op codes still pulse the start bit, so polling stays uniform
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      wr    <= CONTROL_RESET[START_BIT];
      cmd   <= CMD_NONE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch) begin
            wr    <= 1'b1; // RL7
            cmd   <= launch_cmd;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          // the macro times itself; wait for its done
          if (cmd == CMD_NONE || flash_done) state <= ST_DONE;
        end
        ST_DONE: begin
          wr    <= 1'b0; // RL7
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // command pulses and target address
  // one-cycle pulses; the macro times itself from each pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_addr           <= 24'h00_0000;
      flash_program        <= 1'b0;
      flash_erase_page     <= 1'b0;
      flash_erase_general  <= 1'b0;
      config_words_cleared <= 1'b0;
    end else begin
      flash_program       <= launch && launch_cmd == CMD_PROGRAM; // RL8 RL16
      flash_erase_page    <= launch && launch_cmd == CMD_ERASE_PAGE; // RL5
      flash_erase_general <= launch && launch_cmd == CMD_ERASE_GENERAL; // RL15
      // last page also wipes configuration words
      config_words_cleared <= launch && launch_cmd == CMD_ERASE_PAGE
                              && page_base == LAST_PAGE_BASE; // RL18
      if (state == ST_IDLE) begin
        flash_addr <= (launch && launch_cmd == CMD_ERASE_PAGE) ? page_base : table_addr; // RL1
      end
    end
  end

  // ==========================================================
  // checks
  // properties rest while power-on reset is low
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_addr_form: assert property ((state == ST_IDLE && !launch) |=> // RL1
    flash_addr == $past(table_addr)) else $error("table address not formed");
  chk_low_read: assert property ((pready && hit_low && !pwrite) |-> // RL2
    prdata == {16'h0000, $past(flash_rdata[15:0])}) else $error("low read data wrong");
  chk_high_read: assert property ((pready && hit_high && !pwrite) |-> // RL3
    prdata == {24'h00_0000, $past(flash_rdata[23:16])}) else $error("high read data wrong");
  chk_page_align: assert property (flash_erase_page |-> // RL5
    (flash_addr & ~PAGE_ADDR_MASK) == 24'h00_0000) else $error("erase address unaligned");
  chk_stall_hold: assert property (wr |-> (cpu_stall && !pready)) // RL6
    else $error("bus answered during operation");
  chk_start_clear: assert property ((state == ST_DONE) |=> (!wr && state == ST_IDLE)) // RL7
    else $error("start bit not cleared");
  chk_one_cmd: assert property ($onehot0({flash_program, flash_erase_page, // RL8
    flash_erase_general})) else $error("two commands at once");
  chk_unlock_gate: assert property ((start_try && !key_open) |=> (!wr && err)) // RL9
    else $error("locked start not refused");
  chk_enable_gate: assert property ((start_try && !next_program_enable) |=> (!wr && err)) // RL12
    else $error("disabled start not refused");
  chk_code_select: assert property (flash_program |-> // RL14
    (!$past(next_erase) && $past(next_op) == OP_PROGRAM_WORD)) else $error("wrong variant");
  chk_key_relock: assert property ((wr_xfer && !hit_key) |=> // RL9
    (key_state == KEY_LOCKED)) else $error("key not relocked");
  chk_error_clear: assert property ((state == ST_DONE) |=> !err) // RL13
    else $error("error flag kept after completion");
  chk_warm_keep: assert property ((!warm_reset_n && !wr_xfer) |=> // RL17
    $stable(program_enable)) else $error("warm reset changed enable");
  chk_ctrl_zero: assert property ((pready && hit_ctrl && !pwrite) |-> // RL19
    (prdata[12:7] == 6'd0 && prdata[5:4] == 2'd0)) else $error("reserved bits set");
  chk_key_hidden: assert property ((pready && hit_key && !pwrite) |-> // RL20
    prdata == 32'h0000_0000) else $error("key readable");

  cov_program: cover property (flash_program ##[1:100] (state == ST_DONE));
  cov_erase_page: cover property (flash_erase_page ##[1:100] (state == ST_DONE));
  cov_bad_start: cover property (bad_start ##1 err);
  cov_erase_general: cover property (flash_erase_general ##[1:100] (state == ST_DONE));
  cov_last_page: cover property (config_words_cleared ##[1:100] (state == ST_DONE));

endmodule

`default_nettype wire

// ===== sim/flash_macro_model.sv
// behavioural flash macro facing the self-programming controller
// assumes one clock shared with the controller; answers reads one cycle later
`timescale 1ns/10ps
`default_nettype none
module flash_macro_model
  import flash_self_program_pkg::*;
(
  // clock
  input  wire logic        clk,
  // requests from the controller
  input  wire logic [23:0] addr,
  input  wire logic [23:0] wdata,
  input  wire logic        rd,
  input  wire logic        prog,
  input  wire logic        erp,
  input  wire logic        erg,
  // busy time chosen by the bench
  input  wire logic [7:0]  delay,
  // answers
  output logic      [23:0] rdata,
  output logic             done
);
  // ==========================================================
  // storage and timing
  logic [23:0] mem [int];  // sparse array, blank reads all ones
  int          cnt = 0;    // cycles left of a running operation
  int          hold = 0;   // cycles read data stays valid
  logic [23:0] rdata_q = 24'h00_0000;  // read data, starts known
  logic        done_q = 1'b0;          // completion pulse
  assign rdata = rdata_q;
  assign done  = done_q;
  // read data toggles when not held so a stale sample never matches
  always @(posedge clk) begin
    done_q <= 1'b0;
    if (rd) begin
      rdata_q <= mem.exists(addr) ? mem[addr] : 24'hFF_FFFF;
      hold = 2;
    end else if (hold > 0) hold--;
    else rdata_q <= ~rdata_q;
    if (prog) begin
      mem[addr] = wdata;
      cnt = delay + 1;
    end
    if (erp) begin
      for (int i = 0; i < 1024; i++) mem.delete(addr | i);
      cnt = delay + 1;
    end
    if (erg) begin
      mem.delete();
      cnt = delay + 1;
    end
    if (cnt > 0) begin
      cnt--;
      if (cnt == 0) done_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== sim/flash_self_program_control_bench.sv
// self-checking bench for the flash self-programming controller
// assumes the flash macro model and an apb master task on a 40 mhz pclk
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_control_bench
  import flash_self_program_pkg::*;
;
  // ==========================================================
  // signals
  localparam logic [23:0] LAST = 24'h00_3C00;  // last page base, arbitrary
  logic        pclk = 1'b0, presetn = 1'b0, warm_reset_n = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, flash_read, flash_program, flash_done, cpu_stall;
  logic        flash_erase_page, flash_erase_general, config_words_cleared;
  logic [23:0] flash_addr, flash_wdata, flash_rdata, word, fa;
  logic [7:0]  dly = 8'h01;
  int          errors = 0, checks = 0, n_cfg = 0, n_cmd[4] = '{default: 0};
  always #12.5 pclk = ~pclk;
  // pulse counters per command kind
  always @(posedge pclk) begin
    if (flash_program === 1'b1) n_cmd[1]++;
    if (flash_erase_page === 1'b1) n_cmd[2]++;
    if (flash_erase_general === 1'b1) n_cmd[3]++;
    if (config_words_cleared === 1'b1) n_cfg++;
  end
  flash_self_program_control #(.LAST_PAGE_BASE(LAST)) u_dut (
    .pclk(pclk), .presetn(presetn), .warm_reset_n(warm_reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_read(flash_read), .flash_rdata(flash_rdata),
    .flash_program(flash_program), .flash_erase_page(flash_erase_page),
    .flash_erase_general(flash_erase_general), .flash_done(flash_done),
    .config_words_cleared(config_words_cleared), .cpu_stall(cpu_stall));
  flash_macro_model u_flash (
    .clk(pclk), .addr(flash_addr), .wdata(flash_wdata), .rd(flash_read),
    .prog(flash_program), .erp(flash_erase_page), .erg(flash_erase_general),
    .delay(dly), .rdata(flash_rdata), .done(flash_done));
  // ==========================================================
  // tasks
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 400);
    if (pready !== 1'b1) begin errors++; results(); end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(nm, ex, r);
  endtask
  task automatic unlock;
    apb(1'b1, OFF_UNLOCK_KEY, {24'h0, KEY_FIRST}, 4'h1);
    apb(1'b1, OFF_UNLOCK_KEY, {24'h0, KEY_SECOND}, 4'h1);
  endtask
  // control write, stall check, then two quiet slots
  task automatic ctl(input logic [15:0] v, input logic st);
    dly <= 8'($urandom_range(1, 40));
    apb(1'b1, OFF_OP_CONTROL, {16'h0, v}, 4'h3);
    @(negedge pclk);
    fa = flash_addr;
    chk("stall", {31'h0, st}, {31'h0, cpu_stall});
    repeat (2) @(posedge pclk);
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (cpu_stall !== 1'b0 && n < 400) begin @(negedge pclk); n++; end
    if (n >= 400) begin errors++; results(); end
  endtask
  function automatic logic [1:0] exp_cmd(input logic er, input logic [3:0] op);
    if (er && op == 4'b1101) return 2'd3;
    if (er && op == 4'b0010) return 2'd2;
    if (!er && op == 4'b0011) return 2'd1;
    return 2'd0;
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] pg;
    logic [15:0] eff;
    int b[4];
    r = $urandom(32'h4d64);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl reset", OFF_OP_CONTROL, 32'h0000_0000);
    rc("key read", OFF_UNLOCK_KEY, 32'h0000_0000);
    rc("unmapped read", 12'h020, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    $display("test reset done");
    // every code with both variants, unimplemented bits set
    for (int k = 0; k < 32; k++) begin
      b = n_cmd;
      unlock();
      ctl(16'hFFB0 | {9'h0, k[4], 2'b0, k[3:0]}, 1'b1);
      idle();
      rc("ctrl after op", OFF_OP_CONTROL, {16'h4000, 16'h0} >> 16 | {25'h0, k[4], 2'b0, k[3:0]});
      for (int j = 1; j < 4; j++) chk("pulses", 32'(b[j] + (exp_cmd(k[4], k[3:0]) == j)), 32'(n_cmd[j]));
    end
    $display("test opcode sweep done");
    pg = 8'($urandom_range(1, 127));
    eff = 16'($urandom);
    word = 24'($urandom);
    apb(1'b1, OFF_TABLE_PAGE, {24'h0, pg}, 4'h1);
    apb(1'b1, OFF_EFF_ADDR, {16'h0, eff}, 4'h3);
    unlock();
    ctl(16'hC042, 1'b1);
    idle();
    chk("erase base", {8'h0, {pg, eff} & PAGE_ADDR_MASK}, {8'h0, fa});
    apb(1'b1, OFF_TABLE_LOW, {16'h0, word[15:8], 8'($urandom)}, 4'h3);
    apb(1'b1, OFF_TABLE_LOW, {24'h0, word[7:0]}, 4'h1);
    apb(1'b1, OFF_TABLE_HIGH, {24'h0, word[23:16]}, 4'h1);
    unlock();
    ctl(16'hC003, 1'b1);
    chk("prog addr", {8'h0, pg, eff}, {8'h0, fa});
    chk("prog data", {8'h0, word}, {8'h0, flash_wdata});
    idle();
    rc("read low", OFF_TABLE_LOW, {16'h0, word[15:0]});
    rc("read high", OFF_TABLE_HIGH, {24'h0, word[23:16]});
    chk("no config clear", 32'h0, 32'(n_cfg));
    $display("test program done");
    // refused starts: no key, broken key, enable clear
    for (int k = 0; k < 3; k++) begin
      b = n_cmd;
      if (k == 1) apb(1'b1, OFF_UNLOCK_KEY, {24'h0, KEY_FIRST}, 4'h1);
      if (k == 1) apb(1'b1, OFF_TABLE_PAGE, {24'h0, pg}, 4'h1);
      if (k == 1) apb(1'b1, OFF_UNLOCK_KEY, {24'h0, KEY_SECOND}, 4'h1);
      if (k == 2) unlock();
      ctl(k == 2 ? 16'h8003 : 16'hC003, 1'b0);
      rc("refused ctrl", OFF_OP_CONTROL, k == 2 ? 32'h2003 : 32'h6003);
      chk("refused pulses", 32'(b[1]), 32'(n_cmd[1]));
    end
    $display("test refused done");
    apb(1'b1, OFF_TABLE_PAGE, {24'h0, LAST[23:16]}, 4'h1);
    apb(1'b1, OFF_EFF_ADDR, {16'h0, LAST[15:0]}, 4'h3);
    unlock();
    ctl(16'hC042, 1'b1);
    idle();
    chk("config clear", 32'h1, 32'(n_cfg));
    rc("error cleared", OFF_OP_CONTROL, 32'h0000_4042);
    $display("test last page done");
    @(posedge pclk) warm_reset_n <= 1'b0;
    @(posedge pclk) warm_reset_n <= 1'b1;
    rc("warm keeps ctrl", OFF_OP_CONTROL, 32'h0000_4042);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc("power-on clears", OFF_OP_CONTROL, 32'h0000_0000);
    $display("test resets done");
    results();
  end
endmodule
`default_nettype wire
